// ===== core/twm_top.sv
// two-wire master transmitter with an ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================

module twm_top #(
  parameter int unsigned QUARTER = twm_pkg::QUARTER_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq
);

  // sync latency plus sampling must fit well inside one quarter
  if (QUARTER < 8) begin : g_bad_quarter
    $error("quarter period too short");
  end

  typedef enum {S_IDLE, S_WAIT, S_START, S_BIT, S_ACK, S_STOP, S_HOLD} twm_state_e;

  // ==========================================================
  // declarations
  twm_state_e          state_reg;
  twm_pkg::twm_ctrl_s  ctrl_reg;
  twm_pkg::twm_ctrl_s  ctrl_next;
  twm_pkg::twm_ctrl_s  wctl;
  twm_pkg::twm_line_s  lines;
  logic [7:0]          data_reg;
  logic [7:0]          status_reg;
  logic [7:0]          shift_reg;
  logic [3:0]          allow_reg;
  logic [3:0]          mode_reg;
  logic [2:0]          irq_stat_reg;
  logic [2:0]          irq_stat_next;
  logic [2:0]          irq_mask_reg;
  logic [2:0]          bit_reg;
  logic [1:0]          q_reg;
  logic [7:0]          addr_reg;
  logic                wr_pend_reg;
  logic                rd_pend_reg;
  logic                hready_reg;
  logic [31:0]         hrdata_reg;
  logic                irq_reg;
  logic                own_reg;
  logic                first_reg;
  logic                rw_reg;
  logic                ack_reg;
  logic                scl_lo_reg;
  logic                sda_lo_reg;
  logic                ev_reg;
  logic                arb_reg;
  logic                stop_clr_reg;
  logic                prev_sda_reg;
  logic                busy_reg;
  logic                tick;

  // ==========================================================
  // line synchronisers and quarter-bit timing
  twm_sync #(
    .WIDTH (2),
    .RST   (twm_pkg::LINE_RST)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({scl_in, sda_in}),
    .q       (lines)
  );

  // the tick only runs while a bus phase is being shaped
  wire run = (state_reg == S_START) || (state_reg == S_BIT) ||
             (state_reg == S_ACK) || (state_reg == S_STOP);

  twm_tick #(
    .QUARTER (QUARTER)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (run),
    .tick    (tick)
  );

  // ==========================================================
  // ahb-lite address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  // only the low byte of the address is decoded
  wire accept  = hsel & hready & htrans[1];
  wire wr_ctl  = wr_pend_reg & hit(addr_reg, twm_pkg::OFS_CONTROL);
  wire wr_data = wr_pend_reg & hit(addr_reg, twm_pkg::OFS_DATA);
  wire wr_mask = wr_pend_reg & hit(addr_reg, twm_pkg::OFS_IRQ_MASK);
  wire wr_mode = wr_pend_reg & hit(addr_reg, twm_pkg::OFS_MODE);
  wire rd_irq  = rd_pend_reg & hit(addr_reg, twm_pkg::OFS_IRQ_STAT);

  // address phase is registered; reads insert one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hready_reg  <= 1'b1;
    end else begin
      wr_pend_reg <= accept & hwrite;
      rd_pend_reg <= accept & ~hwrite;
      hready_reg  <= ~(accept & ~hwrite);
      if (accept) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  // ==========================================================
  // read data selection, unmapped offsets read zero
  wire [7:0] rd_byte =
    hit(addr_reg, twm_pkg::OFS_CONTROL)  ? ctrl_reg :
    hit(addr_reg, twm_pkg::OFS_STATUS)   ? (status_reg & twm_pkg::STATUS_MASK) :
    hit(addr_reg, twm_pkg::OFS_DATA)     ? data_reg :
    hit(addr_reg, twm_pkg::OFS_IRQ_STAT) ? {5'h00, irq_stat_reg} :
    hit(addr_reg, twm_pkg::OFS_IRQ_MASK) ? {5'h00, irq_mask_reg} :
    hit(addr_reg, twm_pkg::OFS_MODE)     ? {mode_reg, allow_reg} :
    8'h00;

  // read data is taken in the wait cycle, after any earlier write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // bus_control next value
  assign wctl = twm_pkg::twm_ctrl_s'(hwdata[7:0]);

  // a data write counts only while the flag is high
  wire data_ok  = wr_data & ctrl_reg.flag;
  wire wcol_set = wr_data & ~ctrl_reg.flag;

  // hardware set wins over a software clear in the same cycle
  wire flag_nx  = ev_reg | (ctrl_reg.flag & ~(wr_ctl & wctl.flag));
  wire stop_nx  = wr_ctl ? wctl.stop_request
                         : (ctrl_reg.stop_request & ~stop_clr_reg);
  wire wcol_nx  = wcol_set | (ctrl_reg.write_collision & ~data_ok);

  assign ctrl_next = '{
    flag:             flag_nx,
    ack_enable:       wr_ctl ? wctl.ack_enable : ctrl_reg.ack_enable,
    start_request:    wr_ctl ? wctl.start_request : ctrl_reg.start_request,
    stop_request:     stop_nx,
    write_collision:  wcol_nx,
    enable:           wr_ctl ? wctl.enable : ctrl_reg.enable,
    rsvd:             1'b0,
    event_irq_enable: wr_ctl ? wctl.event_irq_enable : ctrl_reg.event_irq_enable
  };

  // ==========================================================
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= twm_pkg::CTRL_RST;
      data_reg     <= twm_pkg::DATA_RST;
      irq_mask_reg <= twm_pkg::MASK_RST;
      allow_reg    <= twm_pkg::ALLOW_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      if (data_ok) begin
        data_reg <= hwdata[7:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= hwdata[2:0];
      end
      if (wr_mode) begin
        allow_reg <= hwdata[3:0];
      end
    end
  end

  // ==========================================================
  // sticky events, cleared by reading; a new event beats the clear
  wire [2:0] irq_ev = {arb_reg, wcol_set, ev_reg};
  assign irq_stat_next = irq_ev | (rd_irq ? 3'h0 : irq_stat_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 3'h0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // bus free detection from start and stop seen on the lines
  wire start_seen = lines.scl & prev_sda_reg & ~lines.sda;
  wire stop_seen  = lines.scl & ~prev_sda_reg & lines.sda;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_sda_reg <= 1'b1;
      busy_reg     <= 1'b0;
    end else begin
      prev_sda_reg <= lines.sda;
      busy_reg     <= ctrl_reg.enable & (start_seen | (busy_reg & ~stop_seen));
    end
  end

  // ==========================================================
  // bit engine helpers
  wire [1:0] q_nx   = q_reg + 2'h1;
  wire       resume = ~ctrl_reg.flag & ~ev_reg;
  wire       go     = ctrl_reg.start_request & ~ctrl_reg.flag & (|allow_reg[1:0]);
  wire       lost   = ~sda_lo_reg & ~lines.sda;

  // code after the acknowledge slot of an address or data byte
  function automatic logic [7:0] ack_code(input logic first, input logic ack);
    if (first) begin
      ack_code = ack ? twm_pkg::CODE_ADDR_ACK : twm_pkg::CODE_ADDR_NACK;
    end else begin
      ack_code = ack ? twm_pkg::CODE_DATA_ACK : twm_pkg::CODE_DATA_NACK;
    end
  endfunction

  // ==========================================================
  // bus sequencer; each phase is four quarters, three when arbitration is lost, q is zero again at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= S_IDLE;
      q_reg        <= 2'h0;
      bit_reg      <= 3'h0;
      shift_reg    <= 8'h00;
      own_reg      <= 1'b0;
      first_reg    <= 1'b0;
      rw_reg       <= 1'b0;
      ack_reg      <= 1'b0;
      scl_lo_reg   <= 1'b0;
      sda_lo_reg   <= 1'b0;
      ev_reg       <= 1'b0;
      arb_reg      <= 1'b0;
      stop_clr_reg <= 1'b0;
      status_reg   <= twm_pkg::CODE_IDLE;
      mode_reg     <= 4'h0;
    end else begin
      ev_reg       <= 1'b0;
      arb_reg      <= 1'b0;
      stop_clr_reg <= 1'b0;
      if (!ctrl_reg.enable) begin
        // disabled: lines released, bus given up at once
        state_reg  <= S_IDLE;
        q_reg      <= 2'h0;
        scl_lo_reg <= 1'b0;
        sda_lo_reg <= 1'b0;
        own_reg    <= 1'b0;
        mode_reg   <= 4'h0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (go) begin
              state_reg <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (!busy_reg) begin
              state_reg <= S_START;
            end
          end
          S_START: begin
            if (tick) begin
              q_reg <= q_nx;
              case (q_reg)
                2'h0: sda_lo_reg <= 1'b0;
                2'h1: scl_lo_reg <= 1'b0;
                2'h2: sda_lo_reg <= 1'b1;
                default: begin
                  scl_lo_reg <= 1'b1;
                  // a start while owning the bus is a repeated start
                  status_reg <= own_reg ? twm_pkg::CODE_RSTART : twm_pkg::CODE_START;
                  own_reg    <= 1'b1;
                  first_reg  <= 1'b1;
                  ev_reg     <= 1'b1;
                  state_reg  <= S_HOLD;
                end
              endcase
            end
          end
          S_BIT: begin
            if (tick) begin
              q_reg <= q_nx;
              case (q_reg)
                2'h0: sda_lo_reg <= ~shift_reg[7];
                2'h1: scl_lo_reg <= 1'b0;
                2'h2: begin
                  if (lost) begin
                    // released a one but the line is low: another master won
                    scl_lo_reg <= 1'b0;
                    sda_lo_reg <= 1'b0;
                    own_reg    <= 1'b0;
                    mode_reg   <= 4'h0;
                    status_reg <= twm_pkg::CODE_ARB_LOST;
                    ev_reg     <= 1'b1;
                    arb_reg    <= 1'b1;
                    q_reg      <= 2'h0;
                    state_reg  <= S_HOLD;
                  end
                end
                default: begin
                  scl_lo_reg <= 1'b1;
                  shift_reg  <= {shift_reg[6:0], 1'b0};
                  bit_reg    <= bit_reg + 3'h1;
                  if (bit_reg == 3'h7) begin
                    state_reg <= S_ACK;
                  end
                end
              endcase
            end
          end
          S_ACK: begin
            if (tick) begin
              q_reg <= q_nx;
              case (q_reg)
                2'h0: sda_lo_reg <= 1'b0;
                2'h1: scl_lo_reg <= 1'b0;
                2'h2: ack_reg    <= ~lines.sda;
                default: begin
                  scl_lo_reg <= 1'b1;
                  status_reg <= ack_code(first_reg, ack_reg);
                  first_reg  <= 1'b0;
                  if (first_reg) begin
                    mode_reg <= rw_reg ? twm_pkg::MODE_MR : twm_pkg::MODE_MT;
                  end
                  ev_reg    <= 1'b1;
                  state_reg <= S_HOLD;
                end
              endcase
            end
          end
          S_STOP: begin
            if (tick) begin
              q_reg <= q_nx;
              case (q_reg)
                2'h0: sda_lo_reg <= 1'b1;
                2'h1: scl_lo_reg <= 1'b0;
                2'h2: sda_lo_reg <= 1'b0;
                default: begin
                  own_reg      <= 1'b0;
                  mode_reg     <= 4'h0;
                  stop_clr_reg <= 1'b1;
                  status_reg   <= twm_pkg::CODE_IDLE;
                  state_reg    <= ctrl_reg.start_request ? S_WAIT : S_IDLE;
                end
              endcase
            end
          end
          S_HOLD: begin
            // scl stays low while software decides, except after a lost arbitration where both lines are free
            if (resume) begin
              if (!own_reg) begin
                state_reg <= ctrl_reg.start_request ? S_WAIT : S_IDLE;
              end else if (ctrl_reg.stop_request) begin
                state_reg <= S_STOP;
              end else if (ctrl_reg.start_request) begin
                state_reg <= S_START;
              end else begin
                state_reg <= S_BIT;
                shift_reg <= data_reg;
                bit_reg   <= 3'h0;
                if (first_reg) begin
                  rw_reg <= data_reg[0];
                end
              end
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // outputs; the pins are open drain, the enable pulls low
  assign hreadyout = hready_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = scl_lo_reg;
  assign sda_oe    = sda_lo_reg;
  assign irq       = irq_reg;

endmodule // twm_top
`default_nettype wire

// ===== core/twm_pkg.sv
// constants, register map and carrier types of the two-wire master transmitter
package twm_pkg;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_MODE     = 8'h14;

  // ==========================================================
  // bus_control layout, most significant bit first
  typedef struct packed {
    logic flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic enable;
    logic rsvd;
    logic event_irq_enable;
  } twm_ctrl_s;

  // synchronised two-wire line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } twm_line_s;

  // ==========================================================
  // reset values
  localparam twm_ctrl_s  CTRL_RST  = '0;
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [2:0] MASK_RST  = 3'h0;
  localparam logic [3:0] ALLOW_RST = 4'hf;
  localparam logic [1:0] LINE_RST  = 2'h3;

  // ==========================================================
  // status codes, the low three bits always read zero
  localparam logic [7:0] STATUS_MASK    = 8'hf8;
  localparam logic [7:0] CODE_START     = 8'h08;
  localparam logic [7:0] CODE_RSTART    = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK  = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK  = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST  = 8'h38;
  localparam logic [7:0] CODE_IDLE      = 8'hf8;

  // ==========================================================
  // one-hot operating modes (allow mask and current mode)
  localparam logic [3:0] MODE_MT = 4'h1;
  localparam logic [3:0] MODE_MR = 4'h2;
  localparam logic [3:0] MODE_ST = 4'h4;
  localparam logic [3:0] MODE_SR = 4'h8;

  // ==========================================================
  // timing: a bit period is split into four quarters
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned BIT_TIME_NS    = 10000;
  localparam int unsigned QUARTER_CYCLES = BIT_TIME_NS / (4 * CLK_PERIOD_NS);

endpackage

// ===== core/twm_sync.sv
// two-flop synchroniser for the two-wire line inputs
`timescale 1ns/1ps
`default_nettype none

module twm_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RST = '1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // ==========================================================
  // first stage feeds only the second; lines idle high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= RST;
      q        <= RST;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // twm_sync
`default_nettype wire

// ===== core/twm_tick.sv
// quarter-bit tick generator for the two-wire bit engine
`timescale 1ns/1ps
`default_nettype none

module twm_tick #(
  parameter int unsigned QUARTER = 500
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  output logic      tick
);

  localparam int unsigned CW = $clog2(QUARTER);

  logic [CW-1:0] cnt_reg;
  wire           last = (cnt_reg == CW'(QUARTER - 1));

  // ==========================================================
  // restarts whenever run drops, so every phase gets full quarters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= run & last;
      cnt_reg <= (!run || last) ? '0 : CW'(cnt_reg + 1'b1);
    end
  end

endmodule // twm_tick
`default_nettype wire

// ===== verification/twm_slave.sv
// two-wire slave receiver model: acks or nacks, records bytes, starts and stops
`timescale 1ns/1ps
`default_nettype none
module twm_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  output var  logic       sda_low,
  output var  logic [7:0] last_byte,
  output var  int         n_start,
  output var  int         n_stop
);
  int         bitc = 0;
  logic [7:0] sh;
  initial sda_low = 1'b0;
  // start and stop: data line moves while the clock line is high
  always @(negedge sda) if (scl === 1'b1) begin
    bitc = 0;
    n_start++;
  end
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  // shift on the rising clock, msb first; byte is whole after eight bits
  always @(posedge scl) if (bitc < 8) begin
    sh = {sh[6:0], sda};
    bitc++;
    if (bitc == 8) last_byte = sh;
  end
  // ack pulled low for one slot; a nack just leaves the pull-up in charge
  always @(negedge scl) if (bitc == 8) begin
    sda_low = ack_en;
    bitc = 9;
  end else if (bitc == 9) begin
    sda_low = 1'b0;
    bitc = 0;
  end
endmodule // twm_slave
`default_nettype wire

// ===== verification/twm_top_sva.sv
// assertion checker for the two-wire master top
`timescale 1ns/1ps
`default_nettype none
module twm_top_sva #(
  parameter int unsigned QUARTER = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  localparam int QLO = QUARTER;
  localparam int QHI = QUARTER + 2;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // bus transfer decode
  wire logic go = hsel && hready && htrans[1];
  wire logic rd = go && !hwrite;
  // ==========================================================
  // assertions
  property p_rd_wait; rd |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_go; go && hwrite |=> hreadyout; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_stat; rd && haddr[7:0] == 8'h04 |-> ##2 hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h0; endproperty
  a_stat: assert property (p_stat) else $error("status low bits not zero");
  property p_rsvd; rd && haddr[7:0] == 8'h00 |-> ##2 !hrdata[1]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bit set");
  property p_off; go && hwrite && haddr[7:0] == 8'h00 ##1 !hwdata[2] |-> ##[1:4] !scl_oe && !sda_oe; endproperty
  a_off: assert property (p_off) else $error("lines held while disabled");
  property p_qtr; $changed(scl_oe) |=> $stable(scl_oe) [*7]; endproperty
  a_qtr: assert property (p_qtr) else $error("clock line quarter too short");
  property p_start; $rose(sda_oe) && !scl_oe |-> ##[QLO:QHI] scl_oe; endproperty
  a_start: assert property (p_start) else $error("start not closed by clock low");
  property p_od; scl_out == 1'b0 && sda_out == 1'b0 && hresp == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open-drain output not low");
endmodule // twm_top_sva
bind twm_top twm_top_sva #(.QUARTER(QUARTER)) sva_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe));
`default_nettype wire

// ===== verification/twm_tb_top.sv
// self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module twm_tb_top;
  // ==========================================================
  // signals; both lines are open drain with pull-ups
  logic        hclk, hresetn, hsel, hwrite, ack_en, jam, rdy, scl_oe, sda_oe, irq, sda_low;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  last_byte;
  int          n_start, n_stop, n_fail, tests_run, cyc;
  wire logic   scl = ~scl_oe;
  wire logic   sda = ~(sda_oe | sda_low | jam);
  twm_top #(.QUARTER(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(), .hrdata(hrdata),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));
  twm_slave slv_u (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_low(sda_low), .last_byte(last_byte),
    .n_start(n_start), .n_stop(n_stop));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  // poll control until the masked bits match
  task automatic wc(input logic [7:0] m, input logic [7:0] v);
    logic [31:0] x;
    do ahb(1'b0, 8'h00, 32'h0, x); while ((x[7:0] & m) !== v);
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] code);
    wr(8'h08, {24'h0, d});
    wr(8'h00, 32'h84);
    wc(8'h80, 8'h80);
    rc(8'h04, {24'h0, code});
    chk({24'h0, last_byte}, {24'h0, d});
    repeat (30) @(posedge hclk);
    chk({31'h0, scl_oe}, 32'h1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc(8'h00, 32'h00);
    rc(8'h04, 32'hf8);
    rc(8'h14, 32'h0f);
    rc(8'h18, 32'h00);
  endtask
  // data write with the flag low is dropped; masked interrupt stays quiet
  task automatic t_coll();
    wr(8'h08, 32'h3c);
    rc(8'h00, 32'h08);
    rc(8'h08, 32'hff);
    chk({31'h0, irq}, 32'h0);
    rc(8'h0c, 32'h2);
    rc(8'h0c, 32'h0);
  endtask
  // no bus activity without enable, or with no master mode allowed
  task automatic t_idle();
    wr(8'h00, 32'ha0);
    repeat (80) @(posedge hclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    wr(8'h14, 32'h0c);
    wr(8'h00, 32'ha4);
    repeat (80) @(posedge hclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    wr(8'h00, 32'h04);
    wr(8'h14, 32'h0f);
  endtask
  // line counts are taken relative, the pins settle from unknown at reset
  task automatic t_xfer();
    int s0, s1;
    s0 = n_stop;
    s1 = n_start;
    wr(8'h10, 32'h7);
    wr(8'h00, 32'ha4);
    wc(8'h80, 8'h80);
    rc(8'h04, 32'h08);
    chk({31'h0, irq}, 32'h1);
    rc(8'h0c, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    send(8'ha0, 8'h18);
    rc(8'h14, 32'h1f);
    send(8'h00, 8'h28);
    send(8'hff, 8'h28);
    wr(8'h00, 32'ha4);
    wc(8'h80, 8'h80);
    rc(8'h04, 32'h10);
    chk(n_stop - s0, 0);
    chk(n_start - s1, 2);
    ack_en <= 1'b0;
    send(8'hb4, 8'h20);
    ack_en <= 1'b1;
    wr(8'h00, 32'hb4);
    wc(8'h90, 8'h80);
    rc(8'h04, 32'h08);
    chk(n_stop - s0, 1);
  endtask
  // another master pulls data low on the first address bit
  task automatic t_arb();
    wr(8'h08, 32'ha0);
    jam <= 1'b1;
    wr(8'h00, 32'h84);
    wc(8'h80, 8'h80);
    rc(8'h04, 32'h38);
    rc(8'h0c, 32'h5);
    jam <= 1'b0;
    wr(8'h00, 32'h84);
    repeat (60) @(posedge hclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    rc(8'h00, 32'h04);
    // disable while holding the bus after a start: both lines let go
    wr(8'h00, 32'ha4);
    wc(8'h80, 8'h80);
    repeat (10) @(posedge hclk);
    wr(8'h00, 32'h80);
    repeat (4) @(posedge hclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ack_en = 1'b1;
    jam = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_coll();
    t_idle();
    t_xfer();
    t_arb();
    summarize();
  end
endmodule // twm_tb_top
`default_nettype wire
